// >>> src/modem_scan_map.vh
// Purpose: Register map, field positions, reset values and timing for the modem status scanner
// Assumes: 32-bit Avalon-MM slave, byte addresses, 200 MHz clock
// Notes: Operation summary follows
// Operation
// - Done bit 7 sets when scan finds a status change on an enabled line.
// - On done, scanning halts, change bits 12-15 and line number 0-3 held.
// - While done, line signal register bits 4-7 show selected modem's present status if its line is enabled, else zero.
// - Done clears on reset and on a one written to scan reset bit 11.
// - Writing one to step bit 8 advances the line number by one unless a scan, a step or a scan reset is running.
// - After a step, a change on the new line sets done if that line is enabled; done never blocks stepping.
// - Step takes written ones only and completes in 1.2 us.
// - Writing one to bit 10 clears enable, ready, send and resync of all lines.
// - Scan reset clears control/status bits 0-3, 5, 6, 7, 9 and 12-15.
// - Scan reset also erases the stored status copy, finishing in 18.8 us.
// - Changes are found by comparing fresh line status with the stored copy.
// - After a scan reset every enabled line with any status on reports a change.
// - Bit 12 sets on either edge of data set ready or reverse channel receive.
// - Bit 13 sets on either edge of the selected modem's clear to send.
// - Bit 14 sets on either edge of the selected modem's carrier.
// - Bit 15 sets only when ring turns on, never when it turns off.
// - Change bits 12-15 are read only, cleared by reset or scan reset.
// - Scan enable bit 5 scans enabled lines while done is clear; clearing stops it.
// - With bit 6 set, done requests a host interrupt.
// - Line number field is a loadable counter, written by software, advanced by hardware.
// - Busy bit 4 reads one while scanning or a scan reset is running.
`ifndef MODEM_SCAN_MAP_VH
`define MODEM_SCAN_MAP_VH

`define MSS_CSR_OFS 4'h0
`define MSS_LSR_OFS 4'h4

`define MSS_LINE_LSB 0
`define MSS_BUSY_BIT 4
`define MSS_SCAN_EN_BIT 5
`define MSS_IRQ_ALLOW_BIT 6
`define MSS_DONE_BIT 7
`define MSS_STEP_BIT 8
`define MSS_MAINT_BIT 9
`define MSS_CLR_MUX_BIT 10
`define MSS_CLR_SCAN_BIT 11
`define MSS_CHG_LSB 12

`define MSS_LSR_EN_BIT 0
`define MSS_LSR_RDY_BIT 1
`define MSS_LSR_RS_BIT 2
`define MSS_LSR_NS_BIT 3
`define MSS_LSR_STAT_LSB 4

`define MSS_CSR_RESET 16'h0000
`define MSS_LINES 16

`define MSS_CLK_PERIOD_PS 5000
`define MSS_STEP_TIME_NS 1200
`define MSS_CLR_SCAN_TIME_NS 18800

`endif

// >>> src/op_timer.v
// Purpose: Down counter that times one step or scan reset operation
// Assumes: load has priority over counting
// Notes: done is a one-cycle pulse when the count expires
`timescale 1ns/1ps
module op_timer #(
  parameter WIDTH = 12
) (
  clk_sys,
  reset_n,
  load,
  count,
  running,
  done
);
  input wire clk_sys;
  input wire reset_n;
  input wire load;
  input wire [WIDTH-1:0] count;
  output wire running;
  output wire done;

  reg [WIDTH-1:0] cnt_q;

  assign running = (cnt_q != {WIDTH{1'b0}});
  assign done = (cnt_q == {{(WIDTH-1){1'b0}}, 1'b1});

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= {WIDTH{1'b0}};
    end else if (load) begin
      cnt_q <= count;
    end else if (running) begin
      cnt_q <= cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule // op_timer

// >>> src/modem_status_scanner.v
// Purpose: Modem status scan logic with control/status and line signal registers
// Assumes: Avalon-MM slave with one wait cycle per access, modem inputs synchronous
// Notes: Status nibble per line is {ring, carrier, clear to send, data set ready or reverse channel receive on async modems}
`timescale 1ns/1ps
`include "modem_scan_map.vh"
module modem_status_scanner #(
  parameter LINES = `MSS_LINES,
  parameter STEP_TIME_NS = `MSS_STEP_TIME_NS,
  parameter CLR_TIME_NS = `MSS_CLR_SCAN_TIME_NS
) (
  clk_sys,
  reset_n,
  avs_address,
  avs_read,
  avs_write,
  avs_writedata,
  avs_byteenable,
  avs_readdata,
  avs_waitrequest,
  dsr_ind,
  reverse_channel_rx_ind,
  async_modem,
  cts_ind,
  carrier_ind,
  ring_ind,
  line_enable,
  term_ready,
  send_request,
  resync_request,
  irq_request
);
  input wire clk_sys;
  input wire reset_n;
  input wire [3:0] avs_address;
  input wire avs_read;
  input wire avs_write;
  input wire [31:0] avs_writedata;
  input wire [3:0] avs_byteenable;
  output reg [31:0] avs_readdata;
  output wire avs_waitrequest;
  input wire [15:0] dsr_ind;
  input wire [15:0] reverse_channel_rx_ind;
  input wire [15:0] async_modem;
  input wire [15:0] cts_ind;
  input wire [15:0] carrier_ind;
  input wire [15:0] ring_ind;
  output wire [15:0] line_enable;
  output wire [15:0] term_ready;
  output wire [15:0] send_request;
  output wire [15:0] resync_request;
  output wire irq_request;

  localparam STEP_CYC = (STEP_TIME_NS * 1000) / `MSS_CLK_PERIOD_PS;
  localparam CLR_CYC = (CLR_TIME_NS * 1000) / `MSS_CLK_PERIOD_PS;
  localparam [11:0] STEP_CNT = STEP_CYC[11:0];
  localparam [11:0] CLR_CNT = CLR_CYC[11:0];
  localparam [15:0] CSR_RST = `MSS_CSR_RESET;

  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_SCAN = 2'b01;
  localparam [1:0] ST_STEP = 2'b10;
  localparam [1:0] ST_CLEAR = 2'b11;

  reg [1:0] state_q;
  reg [3:0] line_q;
  reg scan_en_q;
  reg irq_allow_q;
  reg done_q;
  reg maint_q;
  reg [3:0] chg_q;
  reg ack_q;
  reg [15:0] en_q;
  reg [15:0] rdy_q;
  reg [15:0] rs_q;
  reg [15:0] ns_q;
  reg [3:0] scan_mem [0:15];

  wire [3:0] fresh [0:15];
  wire [3:0] sel_fresh;
  wire [3:0] sel_old;
  wire [3:0] sel_chg;
  wire sel_hit;
  wire acc;
  wire wr_csr;
  wire wr_lsr;
  wire wr_b0;
  wire wr_b1;
  wire step_cmd;
  wire clr_scan_cmd;
  wire clr_mux_cmd;
  wire busy;
  wire tmr_load;
  wire [11:0] tmr_count;
  wire tmr_done;
  wire [3:0] line_inc;
  wire [15:0] csr_rd;
  wire [7:0] lsr_rd;
  integer i;

  genvar g;
  generate
    for (g = 0; g < LINES; g = g + 1) begin : g_fresh
      assign fresh[g] = {ring_ind[g], carrier_ind[g], cts_ind[g],
                         async_modem[g] ? reverse_channel_rx_ind[g] : dsr_ind[g]};
    end
  endgenerate

  // Compare of the selected line against its stored copy
  assign sel_fresh = fresh[line_q];
  assign sel_old = scan_mem[line_q];
  assign sel_chg[0] = sel_fresh[0] ^ sel_old[0];
  assign sel_chg[1] = sel_fresh[1] ^ sel_old[1];
  assign sel_chg[2] = sel_fresh[2] ^ sel_old[2];
  assign sel_chg[3] = sel_fresh[3] & ~sel_old[3];
  assign sel_hit = en_q[line_q] & (sel_chg != 4'h0);
  assign line_inc = line_q + 4'h1;

  // Bus decode; one wait cycle, write takes effect when waitrequest is low
  assign acc = (avs_read | avs_write) & ack_q;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign wr_csr = acc & avs_write & (avs_address == `MSS_CSR_OFS);
  assign wr_lsr = acc & avs_write & (avs_address == `MSS_LSR_OFS) & avs_byteenable[0];
  assign wr_b0 = wr_csr & avs_byteenable[0];
  assign wr_b1 = wr_csr & avs_byteenable[1];
  assign step_cmd = wr_b1 & avs_writedata[`MSS_STEP_BIT];
  assign clr_mux_cmd = wr_b1 & avs_writedata[`MSS_CLR_MUX_BIT];
  assign clr_scan_cmd = wr_b1 & avs_writedata[`MSS_CLR_SCAN_BIT];

  assign busy = (state_q == ST_SCAN) | (state_q == ST_CLEAR);
  assign irq_request = done_q & irq_allow_q;

  assign tmr_load = clr_scan_cmd | (step_cmd & ~clr_scan_cmd & (state_q != ST_CLEAR));
  assign tmr_count = clr_scan_cmd ? CLR_CNT : STEP_CNT;

  op_timer #(
    .WIDTH(12)
  ) u_timer (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .load(tmr_load),
    .count(tmr_count),
    .running(),
    .done(tmr_done)
  );

  assign csr_rd = {chg_q, 1'b0, 1'b0, 1'b0, maint_q, done_q, irq_allow_q, scan_en_q,
                   busy, line_q};
  assign lsr_rd = {(en_q[line_q] ? sel_fresh : 4'h0), ns_q[line_q], rs_q[line_q],
                   rdy_q[line_q], en_q[line_q]};

  assign line_enable = en_q;
  assign term_ready = rdy_q;
  assign send_request = rs_q;
  assign resync_request = ns_q;

  // Bus handshake and read data
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
      if ((avs_read | avs_write) & ~ack_q) begin
        if (avs_address == `MSS_CSR_OFS) begin
          avs_readdata <= {16'h0000, csr_rd};
        end else if (avs_address == `MSS_LSR_OFS) begin
          avs_readdata <= {24'h000000, lsr_rd};
        end else begin
          avs_readdata <= 32'h00000000;
        end
      end
    end
  end

  // Per-line modem controls
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      en_q <= 16'h0000;
      rdy_q <= 16'h0000;
      rs_q <= 16'h0000;
      ns_q <= 16'h0000;
    end else if (clr_mux_cmd) begin
      en_q <= 16'h0000;
      rdy_q <= 16'h0000;
      rs_q <= 16'h0000;
      ns_q <= 16'h0000;
    end else if (wr_lsr) begin
      en_q[line_q] <= avs_writedata[`MSS_LSR_EN_BIT];
      rdy_q[line_q] <= avs_writedata[`MSS_LSR_RDY_BIT];
      rs_q[line_q] <= avs_writedata[`MSS_LSR_RS_BIT];
      ns_q[line_q] <= avs_writedata[`MSS_LSR_NS_BIT];
    end
  end

  // Scan state machine, control/status fields and scan memory
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      line_q <= CSR_RST[`MSS_LINE_LSB+3:`MSS_LINE_LSB];
      scan_en_q <= 1'b0;
      irq_allow_q <= 1'b0;
      done_q <= 1'b0;
      maint_q <= 1'b0;
      chg_q <= 4'h0;
      for (i = 0; i < 16; i = i + 1) begin
        scan_mem[i] <= 4'h0;
      end
    end else if (clr_scan_cmd) begin
      state_q <= ST_CLEAR;
      line_q <= 4'h0;
      scan_en_q <= 1'b0;
      irq_allow_q <= 1'b0;
      done_q <= 1'b0;
      maint_q <= 1'b0;
      chg_q <= 4'h0;
    end else begin
      if (wr_b0) begin
        line_q <= avs_writedata[3:0];
        scan_en_q <= avs_writedata[`MSS_SCAN_EN_BIT];
        irq_allow_q <= avs_writedata[`MSS_IRQ_ALLOW_BIT];
        done_q <= avs_writedata[`MSS_DONE_BIT];
      end
      if (wr_b1) begin
        maint_q <= avs_writedata[`MSS_MAINT_BIT];
      end
      case (state_q)
        ST_IDLE: begin
          if (step_cmd) begin
            line_q <= line_inc;
            state_q <= ST_STEP;
          end else if (scan_en_q & ~done_q & ~wr_b0) begin
            state_q <= ST_SCAN;
          end
        end
        ST_SCAN: begin
          if (~scan_en_q | done_q | (wr_b0 & ~avs_writedata[`MSS_SCAN_EN_BIT])) begin
            state_q <= ST_IDLE;
          end else if (sel_hit) begin
            scan_mem[line_q] <= sel_fresh;
            chg_q <= sel_chg;
            done_q <= 1'b1;
            state_q <= ST_IDLE;
          end else if (!wr_b0) begin
            if (en_q[line_q]) begin
              scan_mem[line_q] <= sel_fresh;
            end
            line_q <= line_inc;
          end
        end
        ST_STEP: begin
          if (tmr_done) begin
            state_q <= ST_IDLE;
            if (en_q[line_q]) begin
              scan_mem[line_q] <= sel_fresh;
            end
            if (sel_hit) begin
              chg_q <= sel_chg;
              done_q <= 1'b1;
            end
          end
        end
        ST_CLEAR: begin
          for (i = 0; i < 16; i = i + 1) begin
            scan_mem[i] <= 4'h0;
          end
          if (tmr_done) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // modem_status_scanner

// >>> test/modem_status_scanner_assertions.sv
// Purpose: Port checks for the modem status scanner
// Assumes: Bound to the scanner top, one clock domain
// Notes: Sees ports only
`timescale 1ns/1ps
module modem_status_scanner_assertions #(
  parameter LINES = 16,
  parameter STEP_TIME_NS = 1200,
  parameter CLR_TIME_NS = 18800
) (
  input wire clk_sys,
  input wire reset_n,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire [15:0] line_enable,
  input wire [15:0] term_ready,
  input wire [15:0] send_request,
  input wire [15:0] resync_request,
  input wire irq_request
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire req = avs_read | avs_write;
  sequence s_taken;
    req && !avs_waitrequest;
  endsequence
  sequence s_wr_csr;
    avs_write && !avs_waitrequest && avs_address == 4'h0;
  endsequence
  chk_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait lasted more than one cycle");
  chk_wait_new: assert property (s_taken |=> !req || avs_waitrequest)
    else $error("new request not held one cycle");
  chk_unmapped_zero: assert property (s_taken ##0 avs_read && avs_address != 4'h0
    && avs_address != 4'h4 |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  chk_upper_zero: assert property (s_taken ##0 avs_read |-> avs_readdata[31:16] == 16'h0)
    else $error("upper read bits not zero");
  chk_clear_mux: assert property (s_wr_csr ##0 avs_byteenable[1] && avs_writedata[10] |=>
    line_enable == 16'h0 && term_ready == 16'h0 && send_request == 16'h0
    && resync_request == 16'h0) else $error("line controls not cleared");
  chk_scan_reset_irq: assert property (s_wr_csr ##0 avs_byteenable[1] && avs_writedata[11]
    |=> !irq_request) else $error("interrupt left after scan reset");
  chk_irq_gate: assert property (s_wr_csr ##0 avs_byteenable[0] && !avs_writedata[6]
    |=> !irq_request) else $error("interrupt without enable");
  chk_reset_quiet: assert property ($rose(reset_n) |-> line_enable == 16'h0 && !irq_request)
    else $error("outputs not clear after reset");
  chk_ctrl_cause: assert property (!$stable(line_enable) |-> $past(avs_write && !avs_waitrequest))
    else $error("line enable moved without a write");
  chk_read_hold: assert property (!$stable(avs_readdata) |-> s_taken)
    else $error("read data changed outside a request");
endmodule // modem_status_scanner_assertions

// >>> test/modem_bank.sv
// Purpose: Sixteen modems whose status lines the bench sets one line at a time
// Assumes: Loads land on the rising clock edge
// Notes: val is {async, reverse rx, ring, carrier, cts, dsr}
`timescale 1ns/1ps
module modem_bank (
  input wire clk_sys,
  input wire load,
  input wire [3:0] sel,
  input wire [5:0] val,
  output reg [15:0] dsr_ind = 16'h0000,
  output reg [15:0] cts_ind = 16'h0000,
  output reg [15:0] carrier_ind = 16'h0000,
  output reg [15:0] ring_ind = 16'h0000,
  output reg [15:0] reverse_channel_rx_ind = 16'h0000,
  output reg [15:0] async_modem = 16'h0000
);
  always @(posedge clk_sys) begin
    if (load) begin
      dsr_ind[sel] <= val[0];
      cts_ind[sel] <= val[1];
      carrier_ind[sel] <= val[2];
      ring_ind[sel] <= val[3];
      reverse_channel_rx_ind[sel] <= val[4];
      async_modem[sel] <= val[5];
    end
  end
endmodule // modem_bank

// >>> test/modem_status_scanner_bench.sv
// Purpose: Register level tests of the modem status scanner
// Assumes: One wait cycle per access, short step and clear times
// Notes: Step 10 cycles, scan reset 20 cycles
`timescale 1ns/1ps
module modem_status_scanner_bench;
  reg clk_sys = 1'b0;
  reg reset_n = 1'b0;
  reg [3:0] avs_address = 4'h0;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h0;
  reg [3:0] avs_byteenable = 4'h0;
  reg load = 1'b0;
  reg [3:0] sel = 4'h0;
  reg [5:0] val = 6'h00;
  reg [31:0] q;
  integer err_count = 0;
  integer comparisons = 0;
  integer i;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  wire irq_request;
  wire [15:0] dsr_ind, reverse_channel_rx_ind, async_modem, cts_ind, carrier_ind, ring_ind;
  wire [15:0] line_enable, term_ready, send_request, resync_request;
  always #2.5 clk_sys = !clk_sys;
  modem_status_scanner #(.STEP_TIME_NS(50), .CLR_TIME_NS(100)) modem_status_scanner_inst (
    .clk_sys, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .dsr_ind, .reverse_channel_rx_ind,
    .async_modem, .cts_ind, .carrier_ind, .ring_ind, .line_enable, .term_ready,
    .send_request, .resync_request, .irq_request);
  modem_bank modem_bank_inst (.clk_sys, .load, .sel, .val, .dsr_ind, .cts_ind,
    .carrier_ind, .ring_ind, .reverse_channel_rx_ind, .async_modem);
  task bus(input [3:0] a, input rd, input [31:0] d, input [3:0] be);
    begin
      avs_address <= a;
      avs_read <= rd;
      avs_write <= !rd;
      avs_writedata <= d;
      avs_byteenable <= be;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0) begin
        @(posedge clk_sys);
      end
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task put(input [3:0] l, input [5:0] v);
    begin
      sel <= l;
      val <= v;
      load <= 1'b1;
      @(posedge clk_sys);
      load <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  task scan_expect(input [3:0] chg, input [3:0] l);
    begin
      bus(4'h0, 0, 32'h60, 4'h1);
      i = 0;
      while (irq_request !== 1'b1 && i < 200) begin
        @(posedge clk_sys);
        i = i + 1;
      end
      bus(4'h0, 1, 0, 4'hF);
      chk(q, {16'h0, chg, 12'h0E0} | l);
    end
  endtask
  task results;
    begin
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin
    #50000;
    err_count = err_count + 1;
    results;
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    bus(4'h0, 1, 0, 4'hF);
    chk(q, 32'h0);
    bus(4'h8, 1, 0, 4'hF);
    chk(q, 32'h0);
    bus(4'hC, 0, 32'hFFFF, 4'hF);
    bus(4'h0, 1, 0, 4'hF);
    chk(q, 32'h0);
    for (i = 0; i < 16; i = i + 1) begin
      bus(4'h0, 0, i, 4'h1);
      bus(4'h4, 0, 32'h07, 4'h1);
    end
    chk(line_enable & term_ready & send_request, 32'hFFFF);
    bus(4'h0, 1, 0, 4'hF);
    chk(q, 32'hF);
    put(4'h3, 6'h05);
    put(4'h4, 6'h04);
    bus(4'h0, 0, 32'h3, 4'h1);
    bus(4'h4, 1, 0, 4'hF);
    chk(q, 32'h57);
    bus(4'h0, 0, 32'h100, 4'h2);
    bus(4'h0, 1, 0, 4'hF);
    chk(q & 32'hFFEF, 32'h4);
    repeat (12) @(posedge clk_sys);
    bus(4'h0, 1, 0, 4'hF);
    chk(q & 32'hFFEF, 32'h4084);
    bus(4'h0, 0, 32'h8F, 4'h1);
    bus(4'h0, 0, 32'h100, 4'h2);
    repeat (12) @(posedge clk_sys);
    bus(4'h0, 1, 0, 4'hF);
    chk(q & 32'h0FEF, 32'h80);
    bus(4'h0, 0, 32'h2E5, 4'h3);
    chk(irq_request, 32'h1);
    bus(4'h0, 0, 32'h800, 4'h2);
    bus(4'h0, 1, 0, 4'hF);
    chk(q, 32'h10);
    repeat (25) @(posedge clk_sys);
    bus(4'h0, 1, 0, 4'hF);
    chk(q, 32'h0);
    scan_expect(4'h5, 4'h3);
    scan_expect(4'h4, 4'h4);
    put(4'h5, 6'h02);
    scan_expect(4'h2, 4'h5);
    put(4'h5, 6'h00);
    scan_expect(4'h2, 4'h5);
    put(4'h4, 6'h00);
    scan_expect(4'h4, 4'h4);
    put(4'h7, 6'h08);
    scan_expect(4'h8, 4'h7);
    put(4'h7, 6'h01);
    scan_expect(4'h1, 4'h7);
    put(4'h9, 6'h30);
    scan_expect(4'h1, 4'h9);
    bus(4'h0, 0, 32'h400, 4'h2);
    chk({line_enable, term_ready}, 32'h0);
    chk({send_request, resync_request}, 32'h0);
    results;
  end
endmodule // modem_status_scanner_bench
bind modem_status_scanner modem_status_scanner_assertions #(.LINES(LINES),
  .STEP_TIME_NS(STEP_TIME_NS), .CLR_TIME_NS(CLR_TIME_NS)) chk_inst (.clk_sys, .reset_n,
  .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
  .avs_waitrequest, .line_enable, .term_ready, .send_request, .resync_request, .irq_request);
